/* File: common/cis_pkg.sv */
// Constants shared by the camera inquiry, status and time-base register bank
package cis_pkg;

   // ---------------------------------------------------------------------
   // Register byte addresses
   // ---------------------------------------------------------------------
   localparam logic [31:0] ADDR_INQ_1      = 32'hf1000040;
   localparam logic [31:0] ADDR_INQ_2      = 32'hf1000044;
   localparam logic [31:0] ADDR_INQ_3      = 32'hf1000048;
   localparam logic [31:0] ADDR_INQ_4      = 32'hf100004c;
   localparam logic [31:0] ADDR_STAT_INFO  = 32'hf1000100;
   localparam logic [31:0] ADDR_STAT_FLAGS = 32'hf1000104;
   localparam logic [31:0] ADDR_SENSOR     = 32'hf1000200;
   localparam logic [31:0] ADDR_UNIT_SEL   = 32'hf1000208;
   localparam logic [31:0] ADDR_EXPO_COUNT = 32'hf1000300;

   // ---------------------------------------------------------------------
   // Field positions (little-endian index; field bit 0 is the word MSB)
   // ---------------------------------------------------------------------
   localparam int POS_PRESENCE   = 31;
   localparam int POS_ARMED      = 16;
   localparam int POS_ISO        = 3;
   localparam int POS_IDLE       = 0;
   localparam int POS_OFFSET_LO  = 12;
   localparam int POS_OFFSET_HI  = 23;
   localparam int POS_UNIT_HI    = 3;
   localparam int POS_COUNT_HI   = 11;

   // ---------------------------------------------------------------------
   // Read-only contents and reset values
   // ---------------------------------------------------------------------
   localparam logic [31:0] INQ_1_VAL       = 32'hc0000000;
   localparam logic [31:0] INQ_2_VAL       = 32'h00000000;
   localparam logic [31:0] INQ_3_VAL       = 32'h80000000;
   localparam logic [31:0] INQ_4_VAL       = 32'h00000000;
   localparam logic [7:0]  IMPL_ID         = 8'h5a; // Arbitrary value
   localparam logic [15:0] SENSOR_ROWS     = 16'h0400;
   localparam logic [15:0] SENSOR_COLUMNS  = 16'h0500;
   localparam logic [11:0] EXPO_OFFSET_US  = 12'h010;
   localparam logic [3:0]  UNIT_CODE_RST   = 4'h4;
   localparam logic [3:0]  UNIT_CODE_MAX   = 4'h9;
   localparam logic [11:0] COUNT_RST       = 12'h001;
   localparam logic [21:0] EXPOSURE_RST    = 22'h000014;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   // ---------------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------------
   localparam int CLK_MHZ          = 200;
   localparam int STATUS_GAP_US    = 5000;
   localparam int STATUS_GAP_CYC   = STATUS_GAP_US * CLK_MHZ;

endpackage

/* File: design/cis_regs.sv */
// Camera inquiry, status and time-base register bank with AXI4-Lite slave
//
// How it works
// R1: Four inquiry words hold one set bit per implemented feature.
// R2: Space of absent features is unmapped and answers with an error.
// R3: Host ignores unnamed inquiry bits; they read as zero here.
// R4: Idle flag set only while neither capturing nor sending.
// R5: Trigger-armed flag follows external trigger mode; idle may coexist.
// R6: Host should poll status no faster than every 5 ms.
// R7: Status read within 5 ms of the previous one is answered late.
// R8: Flags are live copies and may pulse too briefly to be seen.
// R9: Host ignores unnamed status bits; they read as zero here.
// R10: Read-only word with rows in upper and columns in lower half.
// R11: Exposure count is 12 bits, legal 1 to 4095; zero is refused.
// R12: Exposure time equals count times the active time-base unit.
// R13: Unit codes 0 to 9 select 1 to 1000 microseconds.
// R14: After reset the unit is 20 microseconds.
// R15: Unit changes only while idle and takes effect on count write.
// R16: Time-base word reports the fixed exposure offset in microseconds.
// R17: Host treats a zero offset as unknown.
// R18: Absolute-value register space is not implemented.
// R19: Field bit 0 is the word MSB, bit 31 the LSB.
// R20: Writes to read-only fields are ignored.
//
// Design decision made here: the AXI4-Lite interface to the registers.
module cis_regs #(
   parameter int STATUS_GAP_CYC = cis_pkg::STATUS_GAP_CYC
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        capturing,
   input  wire logic        sending,
   input  wire logic        external_trigger_mode,
   input  wire logic        iso_active,
   output logic [11:0]      exposure_count,
   output logic [21:0]      exposure_time_us
);

   // ---------------------------------------------------------------------
   // State
   // ---------------------------------------------------------------------
   typedef enum logic [2:0] {
      RD_IDLE = 3'b001,
      RD_WAIT = 3'b010,
      RD_RESP = 3'b100
   } cis_rd_state_t;

   typedef struct packed {
      cis_rd_state_t rd_state;
      logic [31:0]   ar_addr;
      logic [31:0]   rdata;
      logic [1:0]    rresp;
      logic          aw_held;
      logic [31:0]   aw_addr;
      logic          w_held;
      logic [31:0]   wdata;
      logic [3:0]    wstrb;
      logic          bvalid;
      logic [1:0]    bresp;
      logic [31:0]   gap;
      logic [3:0]    unit_sel;
      logic [3:0]    unit_act;
      logic [11:0]   count;
      logic [21:0]   exposure;
      logic          idle;
      logic          external_trigger_armed;
      logic          iso;
   } cis_state_t;

   cis_state_t st_q;
   cis_state_t st_d;

   localparam logic [31:0] GAP_LIMIT = 32'(STATUS_GAP_CYC);

   // ---------------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------------
   function automatic logic [9:0] cis_unit_us(input logic [3:0] code);
      logic [9:0] u;
      case (code) // R13
         4'h0:    u = 10'd1;
         4'h1:    u = 10'd2;
         4'h2:    u = 10'd5;
         4'h3:    u = 10'd10;
         4'h4:    u = 10'd20;
         4'h5:    u = 10'd50;
         4'h6:    u = 10'd100;
         4'h7:    u = 10'd200;
         4'h8:    u = 10'd500;
         4'h9:    u = 10'd1000;
         default: u = 10'd20;
      endcase
      return u;
   endfunction

   function automatic logic cis_is_status(input logic [31:0] a);
      return (a == cis_pkg::ADDR_STAT_INFO) || (a == cis_pkg::ADDR_STAT_FLAGS);
   endfunction

   // Only the words below exist; everything else, absent features and the
   // absolute-value space included, answers with an error.
   function automatic logic cis_mapped(input logic [31:0] a);
      case (a) // R2 R18
         cis_pkg::ADDR_INQ_1,
         cis_pkg::ADDR_INQ_2,
         cis_pkg::ADDR_INQ_3,
         cis_pkg::ADDR_INQ_4,
         cis_pkg::ADDR_STAT_INFO,
         cis_pkg::ADDR_STAT_FLAGS,
         cis_pkg::ADDR_SENSOR,
         cis_pkg::ADDR_UNIT_SEL,
         cis_pkg::ADDR_EXPO_COUNT: return 1'b1;
         default:                  return 1'b0;
      endcase
   endfunction

   // ---------------------------------------------------------------------
   // Read multiplexer
   // ---------------------------------------------------------------------
   logic [31:0] rd_word;

   always_comb begin
      rd_word = 32'h00000000;
      case (st_q.ar_addr)
         cis_pkg::ADDR_INQ_1: rd_word = cis_pkg::INQ_1_VAL; // R1 R3 R19
         cis_pkg::ADDR_INQ_2: rd_word = cis_pkg::INQ_2_VAL; // R1
         cis_pkg::ADDR_INQ_3: rd_word = cis_pkg::INQ_3_VAL; // R1
         cis_pkg::ADDR_INQ_4: rd_word = cis_pkg::INQ_4_VAL; // R1
         cis_pkg::ADDR_STAT_INFO: begin
            rd_word[cis_pkg::POS_PRESENCE] = 1'b1;
            rd_word[7:0]                   = cis_pkg::IMPL_ID;
         end
         cis_pkg::ADDR_STAT_FLAGS: begin
            rd_word[cis_pkg::POS_IDLE]  = st_q.idle; // R4 R9
            rd_word[cis_pkg::POS_ARMED] = st_q.external_trigger_armed; // R5
            rd_word[cis_pkg::POS_ISO]   = st_q.iso;
         end
         cis_pkg::ADDR_SENSOR: begin
            rd_word = {cis_pkg::SENSOR_ROWS, cis_pkg::SENSOR_COLUMNS}; // R10
         end
         cis_pkg::ADDR_UNIT_SEL: begin
            rd_word[cis_pkg::POS_PRESENCE]                       = 1'b1;
            rd_word[cis_pkg::POS_OFFSET_HI:cis_pkg::POS_OFFSET_LO] =
               cis_pkg::EXPO_OFFSET_US; // R16 R17
            rd_word[cis_pkg::POS_UNIT_HI:0]                      = st_q.unit_sel;
         end
         cis_pkg::ADDR_EXPO_COUNT: rd_word[cis_pkg::POS_COUNT_HI:0] = st_q.count;
         default: rd_word = 32'h00000000;
      endcase
   end

   // ---------------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------------
   logic        wr_go;
   logic [11:0] new_count;
   logic [3:0]  new_sel;

   always_comb begin
      st_d      = st_q;
      wr_go     = st_q.aw_held && st_q.w_held && !st_q.bvalid;
      new_count = {st_q.wstrb[1] ? st_q.wdata[11:8] : st_q.count[11:8],
                   st_q.wstrb[0] ? st_q.wdata[7:0]  : st_q.count[7:0]};
      new_sel   = st_q.wstrb[0] ? st_q.wdata[3:0] : st_q.unit_sel;

      // Flags are plain one-cycle copies, so a short pulse may be missed
      st_d.idle                   = !(capturing || sending); // R4 R8
      st_d.external_trigger_armed = external_trigger_mode; // R5 R8
      st_d.iso                    = iso_active;

      st_d.exposure = 22'(st_q.count * cis_unit_us(st_q.unit_act)); // R12

      if (st_q.gap < GAP_LIMIT) begin
         st_d.gap = st_q.gap + 32'h00000001;
      end

      // Write channel
      if (s_axi_awvalid && !st_q.aw_held) begin
         st_d.aw_held = 1'b1;
         st_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_q.w_held) begin
         st_d.w_held = 1'b1;
         st_d.wdata  = s_axi_wdata;
         st_d.wstrb  = s_axi_wstrb;
      end
      if (st_q.bvalid && s_axi_bready) begin
         st_d.bvalid = 1'b0;
      end
      if (wr_go) begin
         st_d.aw_held = 1'b0;
         st_d.w_held  = 1'b0;
         st_d.bvalid  = 1'b1;
         st_d.bresp   = cis_mapped(st_q.aw_addr) ? cis_pkg::RESP_OKAY
                                                 : cis_pkg::RESP_SLVERR; // R2 R18
         case (st_q.aw_addr)
            cis_pkg::ADDR_UNIT_SEL: begin
               // Refused while busy or out of range, the old code stays
               if (st_q.idle && new_sel <= cis_pkg::UNIT_CODE_MAX) begin
                  st_d.unit_sel = new_sel; // R15
               end
            end
            cis_pkg::ADDR_EXPO_COUNT: begin
               if (new_count != 12'h000) begin
                  st_d.count    = new_count; // R11
                  st_d.unit_act = st_q.unit_sel; // R15
               end
            end
            default: st_d.count = st_q.count; // R20
         endcase
      end

      // Read channel
      case (st_q.rd_state)
         RD_IDLE: begin
            if (s_axi_arvalid) begin
               st_d.ar_addr  = s_axi_araddr;
               st_d.rd_state = RD_WAIT;
            end
         end
         RD_WAIT: begin
            // A fast poller is slowed rather than starving the camera
            if (!(cis_is_status(st_q.ar_addr) && st_q.gap < GAP_LIMIT)) begin // R7
               st_d.rdata    = rd_word;
               st_d.rresp    = cis_mapped(st_q.ar_addr) ? cis_pkg::RESP_OKAY
                                                        : cis_pkg::RESP_SLVERR;
               st_d.rd_state = RD_RESP;
               if (cis_is_status(st_q.ar_addr)) begin
                  st_d.gap = 32'h00000000; // R7
               end
            end
         end
         RD_RESP: begin
            if (s_axi_rready) begin
               st_d.rd_state = RD_IDLE;
            end
         end
         default: st_d.rd_state = RD_IDLE;
      endcase
   end

   // ---------------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q                        <= '0;
         st_q.rd_state               <= RD_IDLE;
         st_q.gap                    <= GAP_LIMIT;
         st_q.unit_sel               <= cis_pkg::UNIT_CODE_RST; // R14
         st_q.unit_act               <= cis_pkg::UNIT_CODE_RST; // R14
         st_q.count                  <= cis_pkg::COUNT_RST;
         st_q.exposure               <= cis_pkg::EXPOSURE_RST;
         st_q.idle                   <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // ---------------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------------
   assign s_axi_awready    = !st_q.aw_held;
   assign s_axi_wready     = !st_q.w_held;
   assign s_axi_bvalid     = st_q.bvalid;
   assign s_axi_bresp      = st_q.bresp;
   assign s_axi_arready    = (st_q.rd_state == RD_IDLE);
   assign s_axi_rvalid     = (st_q.rd_state == RD_RESP);
   assign s_axi_rdata      = st_q.rdata;
   assign s_axi_rresp      = st_q.rresp;
   assign exposure_count   = st_q.count;
   assign exposure_time_us = st_q.exposure;

   // ---------------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------------
   default clocking cis_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   logic unit_wr;
   logic count_wr;
   assign unit_wr  = wr_go && st_q.aw_addr == cis_pkg::ADDR_UNIT_SEL;
   assign count_wr = wr_go && st_q.aw_addr == cis_pkg::ADDR_EXPO_COUNT;

   chk_idle_busy: assert property ( // R4
      (capturing || sending) |=> !st_q.idle)
      else $error("Idle flag set while busy");

   chk_armed_flag: assert property ( // R5
      $rose(external_trigger_mode) |=> st_q.external_trigger_armed)
      else $error("Armed flag did not follow trigger mode");

   chk_status_delay: assert property ( // R7
      (st_q.rd_state == RD_WAIT && cis_is_status(st_q.ar_addr) && st_q.gap < GAP_LIMIT)
      |=> !s_axi_rvalid)
      else $error("Status read answered inside the polling gap");

   chk_status_gap: assert property ( // R7
      (s_axi_rvalid && !$past(s_axi_rvalid) && cis_is_status(st_q.ar_addr))
      |-> st_q.gap == 32'h00000000)
      else $error("Status answer did not restart the gap");

   chk_count_legal: assert property ( // R11
      st_q.count != 12'h000)
      else $error("Exposure count left the legal range");

   chk_expo_product: assert property ( // R12
      ##1 st_q.exposure == 22'($past(st_q.count) * cis_unit_us($past(st_q.unit_act))))
      else $error("Exposure time is not count times unit");

   chk_unit_busy: assert property ( // R15
      (unit_wr && !st_q.idle) |=> $stable(st_q.unit_sel))
      else $error("Unit code changed while busy");

   chk_unit_apply: assert property ( // R15
      (!count_wr && !$rose(aresetn)) |=> $stable(st_q.unit_act))
      else $error("Active unit changed without a count write");

   chk_unmapped_err: assert property ( // R2
      (st_q.rd_state == RD_WAIT && !cis_mapped(st_q.ar_addr))
      |=> s_axi_rvalid && s_axi_rresp == cis_pkg::RESP_SLVERR)
      else $error("Unmapped read did not answer with an error");

   chk_sensor_word: assert property ( // R10
      (s_axi_rvalid && st_q.ar_addr == cis_pkg::ADDR_SENSOR)
      |-> s_axi_rdata == {cis_pkg::SENSOR_ROWS, cis_pkg::SENSOR_COLUMNS})
      else $error("Sensor word read back wrong");

   chk_inq_word: assert property ( // R1
      (s_axi_rvalid && st_q.ar_addr == cis_pkg::ADDR_INQ_1)
      |-> s_axi_rdata == cis_pkg::INQ_1_VAL)
      else $error("Inquiry word read back wrong");

   chk_offset_field: assert property ( // R16
      (s_axi_rvalid && st_q.ar_addr == cis_pkg::ADDR_UNIT_SEL)
      |-> s_axi_rdata[cis_pkg::POS_OFFSET_HI:cis_pkg::POS_OFFSET_LO] == cis_pkg::EXPO_OFFSET_US)
      else $error("Exposure offset field read back wrong");

   chk_unit_range: assert property ( // R13
      st_q.unit_sel <= cis_pkg::UNIT_CODE_MAX)
      else $error("Selected unit code out of range");

   chk_idle_quiet: assert property ( // R4
      !(capturing || sending) |=> st_q.idle)
      else $error("Idle flag clear while quiet");

   chk_zero_count: assert property ( // R11
      (count_wr && new_count == 12'h000) |=> $stable(st_q.count))
      else $error("Zero exposure count was taken");

   chk_ro_ignored: assert property ( // R20
      (wr_go && !unit_wr && !count_wr)
      |=> $stable(st_q.count) && $stable(st_q.unit_sel) && $stable(st_q.unit_act))
      else $error("Write to a read-only word changed state");

   chk_unmapped_wr: assert property ( // R2
      (wr_go && !cis_mapped(st_q.aw_addr))
      |=> s_axi_bvalid && s_axi_bresp == cis_pkg::RESP_SLVERR)
      else $error("Unmapped write did not answer with an error");

endmodule

/* File: test/cis_host.sv */
// Host model: AXI4-Lite master that issues one register access at a time
module cis_host #(
   parameter int LIMIT = 400
) (
   input  wire logic        aclk,
   output logic [31:0]      s_axi_awaddr,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic [31:0]      s_axi_wdata,
   output logic [3:0]       s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   output logic [31:0]      s_axi_araddr,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      s_axi_awaddr  <= 32'h0;
      s_axi_awvalid <= 1'b0;
      s_axi_wdata   <= 32'h0;
      s_axi_wstrb   <= 4'h0;
      s_axi_wvalid  <= 1'b0;
      s_axi_bready  <= 1'b0;
      s_axi_araddr  <= 32'h0;
      s_axi_arvalid <= 1'b0;
      s_axi_rready  <= 1'b0;
   end

   // ---------------------------------------------------------------------
   // Accesses
   // ---------------------------------------------------------------------
   // Address and data valids drop only at the edge that shows ready high, bready at the edge that shows bvalid
   task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r,
                     output bit ok);
      int n;
      ok = 1'b0;
      r = 2'h3;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= 4'hf;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (n = 0; n < LIMIT && !ok; n++) begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            ok = 1'b1;
         end
      end
   endtask

   // Status polls are issued back to back on request, ignoring the polling gap
   task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r,
                     output int n, output bit ok);
      ok = 1'b0;
      r = 2'h3;
      d = 32'h0;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (n = 0; n < LIMIT && !ok; n++) begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            ok = 1'b1;
         end
      end
   endtask
endmodule

/* File: test/cis_regs_tb.sv */
// Self-checking bench for the inquiry, status and time-base register bank
module cis_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int GAP = 40;
   logic        aclk, aresetn, capturing, sending, external_trigger_mode, iso_active;
   logic [31:0] awaddr, wdata, araddr, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [11:0] exposure_count;
   logic [21:0] exposure_time_us;
   int          errors, n_compared, i, cnt, exp_t, n;
   int          unit_us[10] = '{1, 2, 5, 10, 20, 50, 100, 200, 500, 1000};

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   cis_regs #(.STATUS_GAP_CYC(GAP)) cis_regs_i (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .capturing(capturing), .sending(sending), .external_trigger_mode(external_trigger_mode),
      .iso_active(iso_active), .exposure_count(exposure_count),
      .exposure_time_us(exposure_time_us));

   cis_host cis_host_i (
      .aclk(aclk),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   // ---------------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out();
      if (errors == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] rexp);
      logic [31:0] d;
      logic [1:0]  r;
      bit          ok;
      cis_host_i.rd(a, d, r, n, ok);
      chk("read done", {31'h0, ok}, 32'h1);
      if (!ok) begin
         close_out();
      end else begin
         chk("read data", d, exp);
         chk("read response", {30'h0, r}, {30'h0, rexp});
      end
   endtask

   task automatic wr_chk(input logic [31:0] a, input logic [31:0] d, input logic [1:0] rexp);
      logic [1:0] r;
      bit         ok;
      cis_host_i.wr(a, d, r, ok);
      chk("write done", {31'h0, ok}, 32'h1);
      if (!ok) begin
         close_out();
      end else begin
         chk("write response", {30'h0, r}, {30'h0, rexp});
      end
   endtask

   function automatic logic [31:0] unit_word(input logic [3:0] code);
      return 32'h80000000 | ({20'h0, cis_pkg::EXPO_OFFSET_US} << 12) | {28'h0, code};
   endfunction

   // ---------------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------------
   initial begin
      errors = 0;
      n_compared = 0;
      aresetn <= 1'b0;
      capturing <= 1'b0;
      sending <= 1'b0;
      external_trigger_mode <= 1'b0;
      iso_active <= 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd_chk(cis_pkg::ADDR_INQ_1, cis_pkg::INQ_1_VAL, cis_pkg::RESP_OKAY);
      rd_chk(cis_pkg::ADDR_INQ_2, cis_pkg::INQ_2_VAL, cis_pkg::RESP_OKAY);
      rd_chk(cis_pkg::ADDR_INQ_3, cis_pkg::INQ_3_VAL, cis_pkg::RESP_OKAY);
      rd_chk(cis_pkg::ADDR_INQ_4, cis_pkg::INQ_4_VAL, cis_pkg::RESP_OKAY);
      rd_chk(cis_pkg::ADDR_SENSOR, {cis_pkg::SENSOR_ROWS, cis_pkg::SENSOR_COLUMNS},
             cis_pkg::RESP_OKAY);
      rd_chk(cis_pkg::ADDR_UNIT_SEL, unit_word(4'h4), cis_pkg::RESP_OKAY);
      chk("exposure_time_us", {10'h0, exposure_time_us}, 32'h14);
      chk("exposure_count", {20'h0, exposure_count}, {20'h0, cis_pkg::COUNT_RST});
      wr_chk(cis_pkg::ADDR_SENSOR, 32'hffffffff, cis_pkg::RESP_OKAY);
      rd_chk(cis_pkg::ADDR_SENSOR, {cis_pkg::SENSOR_ROWS, cis_pkg::SENSOR_COLUMNS},
             cis_pkg::RESP_OKAY);
      wr_chk(cis_pkg::ADDR_UNIT_SEL, 32'h00000004, cis_pkg::RESP_OKAY);
      rd_chk(cis_pkg::ADDR_UNIT_SEL, unit_word(4'h4), cis_pkg::RESP_OKAY);
      wr_chk(32'hf1000400, 32'h0, cis_pkg::RESP_SLVERR);
      rd_chk(32'hf1000400, 32'h0, cis_pkg::RESP_SLVERR);
      // New unit must not act until the count is written again
      exp_t = 20;
      for (i = 0; i < 10; i++) begin
         cnt = (i == 9) ? 4095 : i + 1;
         wr_chk(cis_pkg::ADDR_UNIT_SEL, i, cis_pkg::RESP_OKAY);
         rd_chk(cis_pkg::ADDR_UNIT_SEL, unit_word(i[3:0]), cis_pkg::RESP_OKAY);
         chk("time before count", {10'h0, exposure_time_us}, exp_t);
         wr_chk(cis_pkg::ADDR_EXPO_COUNT, cnt, cis_pkg::RESP_OKAY);
         repeat (2) @(posedge aclk);
         exp_t = cnt * unit_us[i];
         chk("exposure_count", {20'h0, exposure_count}, cnt);
         chk("exposure_time_us", {10'h0, exposure_time_us}, exp_t);
      end
      wr_chk(cis_pkg::ADDR_UNIT_SEL, 32'ha, cis_pkg::RESP_OKAY);
      rd_chk(cis_pkg::ADDR_UNIT_SEL, unit_word(4'h9), cis_pkg::RESP_OKAY);
      wr_chk(cis_pkg::ADDR_EXPO_COUNT, 32'h0, cis_pkg::RESP_OKAY);
      chk("count zero", {20'h0, exposure_count}, 32'hfff);
      capturing <= 1'b1;
      repeat (3) @(posedge aclk);
      wr_chk(cis_pkg::ADDR_UNIT_SEL, 32'h2, cis_pkg::RESP_OKAY);
      rd_chk(cis_pkg::ADDR_UNIT_SEL, unit_word(4'h9), cis_pkg::RESP_OKAY);
      capturing <= 1'b0;
      sending <= 1'b1;
      external_trigger_mode <= 1'b1;
      iso_active <= 1'b1;
      repeat (3) @(posedge aclk);
      rd_chk(cis_pkg::ADDR_STAT_FLAGS, 32'h00010008, cis_pkg::RESP_OKAY);
      sending <= 1'b0;
      repeat (3) @(posedge aclk);
      rd_chk(cis_pkg::ADDR_STAT_FLAGS, 32'h00010009, cis_pkg::RESP_OKAY);
      external_trigger_mode <= 1'b0;
      iso_active <= 1'b0;
      repeat (3) @(posedge aclk);
      rd_chk(cis_pkg::ADDR_STAT_FLAGS, 32'h00000001, cis_pkg::RESP_OKAY);
      // A poll after a quiet spell is quick, the one right after it is held back
      repeat (2 * GAP) @(posedge aclk);
      rd_chk(cis_pkg::ADDR_STAT_INFO, {24'h800000, cis_pkg::IMPL_ID}, cis_pkg::RESP_OKAY);
      chk("quick status answer", {31'h0, n < 8}, 32'h1);
      rd_chk(cis_pkg::ADDR_STAT_FLAGS, 32'h00000001, cis_pkg::RESP_OKAY);
      chk("held status answer", {31'h0, n >= GAP - 8}, 32'h1);
      close_out();
   end
endmodule
